/* bench/instruction_state_timing_tb.sv */
// self-checking bench for the instruction state timing engine
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module instruction_state_timing_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, nrst = 1'b0, alb = 1'b0, muxed = 1'b0, b8 = 1'b0, seq_start = 1'b0, valid = 1'b0;
   logic lng = 1'b0, taken = 1'b0, hit = 1'b0, ropnd = 1'b0, iopnd = 1'b0, pauto = 1'b0;
   logic [7:0] sys_cfg = 8'h00, ist, ex;
   logic [2:0] cls = 3'h0;
   logic [1:0] src = 2'h0, grant;
   logic [31:0] rnd = 32'h4B6F;
   logic rw, rf, rr, ready, done, tick;
   logic [5:0] eas;
   logic [15:0] tot, sum;
   int miscompares = 0, samples_checked = 0, wt;
   always #50 clk_sys = ~clk_sys;
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xs
   always @(posedge clk_sys) rnd <= xs(rnd);
   // access cycle length from the bus mode and wait fields
   function automatic logic [7:0] act_f();
      return (muxed ? 8'h03 : 8'h02) + 8'(4'hF - sys_cfg[3:0]) + 8'(!sys_cfg[5]) + 8'(alb);
   endfunction : act_f
   // expected states of the instruction now presented
   function automatic logic [7:0] cost_f();
      logic [7:0] m;
      m = (cls == 3'h3) ? 8'h0A : (cls == 3'h4) ? 8'h14 : (cls == 3'h2 || (cls == 3'h1 && taken && !hit)) ? 8'h04 : 8'h02;
      m = m + (ropnd ? 8'h02 : 8'h00) + ((iopnd && pauto) ? 8'h01 : 8'h00);
      if (hit || src == 2'h0) return m;
      if (src == 2'h1) return m + (lng ? 8'h06 : 8'h04);
      return 8'((lng ? 2 : 1) * (b8 ? 2 : 1)) * act_f() + m - 8'h02;
   endfunction : cost_f
   ist_timing uut (.clk_sys, .nrst, .sys_cfg, .address_latch_lengthen_bit(alb), .bus_muxed(muxed), .bus_8bit(b8),
      .seq_start, .instr_valid(valid), .instr_cls(cls), .instr_src(src), .instr_long(lng), .branch_taken(taken),
      .cache_hit(hit), .rom_opnd(ropnd), .ind_ram_opnd(iopnd), .prev_autostep(pauto), .req_write(rw),
      .req_fetch(rf), .req_read(rr), .instr_ready(ready), .instr_done(done), .state_tick(tick),
      .ext_access_states(eas), .instr_states(ist), .total_states(tot), .bus_grant(grant));
   ist_mem_model u_mem (.clk_sys, .nrst, .rnd, .req_write(rw), .req_fetch(rf), .req_read(rr));
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results
   // watchdog well beyond the longest expected run
   initial begin
      #3000000;
      miscompares++;
      results();
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      // wait field and tristate corners first, then random settings
      for (int i = 0; i < 24; i++) begin
         @(posedge clk_sys);
         {alb, muxed, b8} <= rnd[2:0];
         sys_cfg <= (i < 4) ? {2'h0, i[0], 1'b0, {4{i[1]}}} : rnd[15:8];
         @(negedge clk_sys);
         `CHK("ext_access_states", act_f(), {2'h0, eas})
      end
      @(posedge clk_sys);
      seq_start <= 1'b1;
      @(posedge clk_sys);
      seq_start <= 1'b0;
      sum = 16'h0006;
      // random instructions back to back, each held until taken
      for (int i = 0; i < 40; i++) begin
         @(posedge clk_sys);
         cls <= 3'(rnd % 5);
         src <= 2'(rnd[7:4] % 3);
         {lng, taken, hit, ropnd, iopnd, pauto} <= rnd[13:8];
         valid <= 1'b1;
         wt = 0;
         @(negedge clk_sys);
         while (ready !== 1'b1 && wt < 400) begin
            @(negedge clk_sys);
            wt++;
         end
         ex = cost_f();
         sum = sum + 16'(ex);
         @(posedge clk_sys);
         valid <= 1'b0;
         wt = 0;
         @(negedge clk_sys);
         while (done !== 1'b1 && wt < 600) begin
            @(negedge clk_sys);
            wt++;
         end
         `CHK("instr_states", ex, ist)
      end
      @(negedge clk_sys);
      `CHK("total_states", sum, tot)
      results();
   end
endmodule : instruction_state_timing_tb
`default_nettype wire

/* bench/ist_mem_model.sv */
// external memory side: raises colliding bus requests
`default_nettype none
module ist_mem_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [31:0] rnd,
   output logic req_write,
   output logic req_fetch,
   output logic req_read
);
   // fresh random requests each clock so all three often collide
   always_ff @(posedge clk_sys) begin
      if (!nrst) {req_write, req_fetch, req_read} <= 3'h0;
      else {req_write, req_fetch, req_read} <= rnd[2:0];
   end
endmodule : ist_mem_model
`default_nettype wire

/* bench/ist_timing_chk.sv */
// port checker for the instruction state timing engine
`default_nettype none
module ist_timing_chk (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [7:0] sys_cfg,
   input wire logic address_latch_lengthen_bit,
   input wire logic bus_muxed,
   input wire logic req_write,
   input wire logic req_fetch,
   input wire logic req_read,
   input wire logic instr_done,
   input wire logic state_tick,
   input wire logic [5:0] ext_access_states,
   input wire logic [1:0] bus_grant
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // wait states on top of the base length
   logic [5:0] wt;
   assign wt = 6'(4'hF - sys_cfg[3:0]) + 6'(!sys_cfg[5]) + 6'(address_latch_lengthen_bit);
   // one state: a quiet clock, then the tick clock
   sequence s_state;
      !state_tick ##1 state_tick;
   endsequence
   a_tick_pulse: assert property (state_tick |=> s_state)
      else $error("state tick not every second clock");
   a_done_tick: assert property (instr_done |-> state_tick)
      else $error("instruction ends off a state boundary");
   a_demux_len: assert property (!bus_muxed |-> ext_access_states == 6'h02 + wt)
      else $error("demuxed access length wrong");
   a_mux_len: assert property (bus_muxed |-> ext_access_states == 6'h03 + wt)
      else $error("muxed access length wrong");
   a_grant_write: assert property (req_write |=> bus_grant == 2'h1)
      else $error("write not served first");
   a_grant_fetch: assert property (!req_write && req_fetch |=> bus_grant == 2'h2)
      else $error("fetch not served second");
   a_grant_read: assert property (!req_write && !req_fetch && req_read |=> bus_grant == 2'h3)
      else $error("read not served");
   a_grant_idle: assert property (!(req_write || req_fetch || req_read) |=> bus_grant == 2'h0)
      else $error("grant without request");
endmodule : ist_timing_chk
bind ist_timing ist_timing_chk u_chk (.clk_sys, .nrst, .sys_cfg, .address_latch_lengthen_bit, .bus_muxed,
   .req_write, .req_fetch, .req_read, .instr_done, .state_tick, .ext_access_states, .bus_grant);
`default_nettype wire

/* shared/ist_pkg.sv */
// package of constants and types for the instruction state timing block
`default_nettype none
package ist_pkg;
   // oscillator periods per state
   localparam logic [1:0] OSC_PER_STATE = 2'h2;
   // external access cycle base states
   localparam logic [5:0] ACT_BASE_DEMUX = 6'h02;
   localparam logic [5:0] ACT_BASE_MUX = 6'h03;
   localparam logic [3:0] WAIT_FIELD_MAX = 4'hF;
   // configuration field positions
   localparam int CFG_WAIT_LSB = 0;
   localparam int CFG_WAIT_MSB = 3;
   localparam int CFG_TRI_BIT = 5;
   // state counts
   localparam logic [7:0] FILL_STATES = 8'h06;
   localparam logic [7:0] MIN_STATES = 8'h02;
   localparam logic [7:0] BRANCH_STATES = 8'h04;
   localparam logic [7:0] MUL_STATES = 8'h0A;
   localparam logic [7:0] DIV_STATES = 8'h14;
   localparam logic [7:0] RAM_ADD_SHORT = 8'h04;
   localparam logic [7:0] RAM_ADD_LONG = 8'h06;
   localparam logic [7:0] ROM_OPND_ADD = 8'h02;
   localparam logic [7:0] IND_RAM_ADD = 8'h01;
   localparam logic [7:0] ONE_STATE = 8'h01;
   // instruction classes
   typedef enum logic [2:0] {
      IST_CLS_PLAIN = 3'b000,
      IST_CLS_BRANCH = 3'b001,
      IST_CLS_LONG4 = 3'b010,
      IST_CLS_MUL = 3'b011,
      IST_CLS_DIV = 3'b100
   } ist_cls_e;
   // fetch sources
   typedef enum logic [1:0] {
      IST_SRC_ROM = 2'b00,
      IST_SRC_RAM = 2'b01,
      IST_SRC_EXT = 2'b10
   } ist_src_e;
   // bus requesters
   typedef enum logic [1:0] {
      IST_REQ_NONE = 2'b00,
      IST_REQ_WRITE = 2'b01,
      IST_REQ_FETCH = 2'b10,
      IST_REQ_READ = 2'b11
   } ist_req_e;
   // states of the timing engine
   typedef enum logic [1:0] {
      IST_ST_IDLE = 2'b00,
      IST_ST_FILL = 2'b01,
      IST_ST_EXEC = 2'b10
   } ist_state_e;
endpackage : ist_pkg
`default_nettype wire

/* verilog/ist_timing.sv */
// instruction state timing engine with external bus arbitration
//
// Summary of operation
// - one state equals two oscillator periods
// - demuxed access cycle two states plus waits
// - muxed access cycle three states plus waits
// - sequence adds six states pipeline fill
// - most internal program memory instructions two states
// - branches four taken, two untaken or cached
// - multiply ten, divide twenty, IST_CLS_LONG4 four
// - cached jump target timed as internal memory
// - internal RAM adds four or six states
// - 16-bit external: cycles plus minimum less two
// - 8-bit external bus doubles access cycles
// - internal memory timing ignores instruction length
// - internal memory operand read adds two states
// - register or direct RAM read adds nothing
// - indirect RAM after auto-step adds one
// - bus unit runs alongside the core
// - bus priority: write, fetch, then read
// - wait field bits 3:0, tristate bit 5
`default_nettype none
module ist_timing (
   input wire logic clk_sys, // oscillator clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic [7:0] sys_cfg, // system_configuration low byte
   input wire logic address_latch_lengthen_bit, // adds one state per access
   input wire logic bus_muxed, // multiplexed external bus mode
   input wire logic bus_8bit, // 8-bit external data bus
   input wire logic seq_start, // begin a sequence (pipeline fill)
   input wire logic instr_valid, // instruction presented
   input wire logic [2:0] instr_cls, // ist_cls_e
   input wire logic [1:0] instr_src, // ist_src_e
   input wire logic instr_long, // 4-byte instruction
   input wire logic branch_taken, // branch condition met
   input wire logic cache_hit, // target injected from jump cache
   input wire logic rom_opnd, // operand read from internal program memory
   input wire logic ind_ram_opnd, // indirect internal RAM operand read
   input wire logic prev_autostep, // previous instruction auto-stepped a register
   input wire logic req_write, // data write wants external bus
   input wire logic req_fetch, // code fetch wants external bus
   input wire logic req_read, // data read wants external bus
   output logic instr_ready, // engine accepts an instruction
   output logic instr_done, // one-cycle pulse at instruction end
   output logic state_tick, // one-cycle pulse per state
   output logic [5:0] ext_access_states, // external_access_cycle_time in states
   output logic [7:0] instr_states, // states charged to last instruction
   output logic [15:0] total_states, // states since sequence start
   output logic [1:0] bus_grant // ist_req_e granted this cycle
);
   // state phase within one state
   logic [1:0] phase_r, phase_nxt;
   // engine state and remaining states
   ist_pkg::ist_state_e st_r, st_nxt;
   logic [7:0] left_r, left_nxt;
   logic [7:0] last_r, last_nxt;
   logic [15:0] tot_r, tot_nxt;
   logic [1:0] grant_r, grant_nxt;
   // combinational helpers
   logic [3:0] wait_fld;
   logic tri_bit;
   logic [5:0] act;
   logic [7:0] cost;
   logic tick;

   // access cycle wait contributions from configuration fields
   assign wait_fld = sys_cfg[ist_pkg::CFG_WAIT_MSB:ist_pkg::CFG_WAIT_LSB];
   assign tri_bit = sys_cfg[ist_pkg::CFG_TRI_BIT];

   // state boundary: last oscillator period of a state
   assign tick = (phase_r == ist_pkg::OSC_PER_STATE - 2'h1);

   // minimum internal program memory cost of a class
   function automatic logic [7:0] rom_min(input logic [2:0] cls, input logic taken, input logic hit);
      logic [7:0] c;
      c = ist_pkg::MIN_STATES;
      case (cls)
         ist_pkg::IST_CLS_BRANCH: c = (taken && !hit) ? ist_pkg::BRANCH_STATES : ist_pkg::MIN_STATES;
         ist_pkg::IST_CLS_LONG4: c = ist_pkg::BRANCH_STATES;
         ist_pkg::IST_CLS_MUL: c = ist_pkg::MUL_STATES;
         ist_pkg::IST_CLS_DIV: c = ist_pkg::DIV_STATES;
         default: c = ist_pkg::MIN_STATES;
      endcase
      return c;
   endfunction : rom_min

   // access cycle length and instruction cost
   always_comb begin
      logic [7:0] rmin;
      logic [7:0] ncyc;
      logic [7:0] ext;
      rmin = rom_min(instr_cls, branch_taken, cache_hit);
      // base plus complemented waits plus inverted tristate bit plus lengthen bit
      act = (bus_muxed ? ist_pkg::ACT_BASE_MUX : ist_pkg::ACT_BASE_DEMUX)
         + {2'h0, ist_pkg::WAIT_FIELD_MAX - wait_fld}
         + {5'h00, ~tri_bit}
         + {5'h00, address_latch_lengthen_bit};
      ncyc = instr_long ? 8'h02 : 8'h01;
      if (bus_8bit) begin
         ncyc = {ncyc[6:0], 1'b0};
      end
      ext = 8'(ncyc * {2'h0, act}) + rmin - ist_pkg::MIN_STATES;
      if (cache_hit || instr_src == ist_pkg::IST_SRC_ROM) begin
         cost = rmin;
      end else if (instr_src == ist_pkg::IST_SRC_RAM) begin
         cost = rmin + (instr_long ? ist_pkg::RAM_ADD_LONG : ist_pkg::RAM_ADD_SHORT);
      end else begin
         cost = ext;
      end
      if (rom_opnd) begin
         cost = cost + ist_pkg::ROM_OPND_ADD;
      end
      // direct RAM and register reads cost nothing extra
      if (ind_ram_opnd && prev_autostep) begin
         cost = cost + ist_pkg::IND_RAM_ADD;
      end
   end

   // next state of the timing engine
   always_comb begin
      phase_nxt = tick ? 2'h0 : phase_r + 2'h1;
      st_nxt = st_r;
      left_nxt = left_r;
      last_nxt = last_r;
      tot_nxt = tot_r;
      if (tick && st_r != ist_pkg::IST_ST_IDLE) begin
         tot_nxt = tot_r + 16'h0001;
      end
      if (seq_start) begin
         // pipeline fill overhead
         st_nxt = ist_pkg::IST_ST_FILL;
         left_nxt = ist_pkg::FILL_STATES;
         tot_nxt = 16'h0000;
         // phase runs on untouched so every state stays two clocks long
      end else begin
         case (st_r)
            ist_pkg::IST_ST_IDLE: begin
               st_nxt = ist_pkg::IST_ST_IDLE;
            end
            ist_pkg::IST_ST_FILL: begin
               if (tick) begin
                  left_nxt = left_r - ist_pkg::ONE_STATE;
                  if (left_r == ist_pkg::ONE_STATE) begin
                     st_nxt = ist_pkg::IST_ST_EXEC;
                     left_nxt = 8'h00;
                  end
               end
            end
            ist_pkg::IST_ST_EXEC: begin
               if (left_r == 8'h00) begin
                  if (instr_valid && phase_r == 2'h0) begin
                     left_nxt = cost;
                     last_nxt = cost;
                  end
               end else if (tick) begin
                  left_nxt = left_r - ist_pkg::ONE_STATE;
               end
            end
            default: begin
               st_nxt = ist_pkg::IST_ST_IDLE;
            end
         endcase
      end
   end

   // external bus unit arbitration, independent of core timing
   always_comb begin
      if (req_write) begin
         grant_nxt = ist_pkg::IST_REQ_WRITE;
      end else if (req_fetch) begin
         grant_nxt = ist_pkg::IST_REQ_FETCH;
      end else if (req_read) begin
         grant_nxt = ist_pkg::IST_REQ_READ;
      end else begin
         grant_nxt = ist_pkg::IST_REQ_NONE;
      end
   end

   // register all state
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         phase_r <= 2'h0;
         st_r <= ist_pkg::IST_ST_IDLE;
         left_r <= 8'h00;
         last_r <= 8'h00;
         tot_r <= 16'h0000;
         grant_r <= ist_pkg::IST_REQ_NONE;
      end else begin
         phase_r <= phase_nxt;
         st_r <= st_nxt;
         left_r <= left_nxt;
         last_r <= last_nxt;
         tot_r <= tot_nxt;
         grant_r <= grant_nxt;
      end
   end

   // outputs
   assign instr_ready = (st_r == ist_pkg::IST_ST_EXEC) && (left_r == 8'h00) && (phase_r == 2'h0);
   assign instr_done = (st_r == ist_pkg::IST_ST_EXEC) && tick && (left_r == ist_pkg::ONE_STATE);
   assign state_tick = tick;
   assign ext_access_states = act;
   assign instr_states = last_r;
   assign total_states = tot_r;
   assign bus_grant = grant_r;
endmodule : ist_timing
`default_nettype wire
